// >>> rtl/imsc_ctrl.sv
// Two-wire bus controller, master or slave, 7-bit or 10-bit addressing.
// Assumes firmware holds address, buffer and stop inputs steady while pending.
`timescale 1ns/100ps
module imsc_ctrl
  import imsc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic linkClk,
  input wire logic controllerEnable,
  input wire logic roleSelect,
  input wire logic [1:0] clockRateSelect,
  input wire logic clockSourceChoice,
  input wire logic speedSelect,
  input wire logic tenBitOwn,
  input wire logic [7:0] targetAddressReg,
  input wire logic [9:0] ownAddressReg,
  input wire logic [7:0] bufferWrData,
  input wire logic bufferWrite,
  input wire logic strobeSet,
  input wire logic stopBit,
  input wire logic repeatStart,
  input wire logic pendClear,
  input wire logic [2:0] flagClear,
  input wire logic [2:0] intEnable,
  output logic [7:0] byteBuffer,
  output logic pending,
  output logic transmitDoneFlag,
  output logic receiveDoneFlag,
  output logic stopSeenFlag,
  output logic irqReq,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe
);

  // ****************************************
  // Crossings
  // ****************************************
  logic strobeReq;
  logic pendReq;
  logic strobeGo;
  logic pendGo;
  logic evTx;
  logic evRx;
  logic evStop;
  logic refTx;
  logic refRx;
  logic refStop;
  logic [16:0] cfgS;
  logic [1:0] pinS;
  logic linkEn;
  logic linkRole;
  logic [1:0] linkRate;
  logic linkSrc;
  logic linkSpeed;
  logic linkTen;
  logic [9:0] linkOwn;
  logic sclS;
  logic sdaS;

  imsc_pulse_xing uStrobe (.srcClk(ref_clk), .dstClk(linkClk), .nrst(nrst),
    .srcPulse(strobeReq), .dstPulse(strobeGo));
  imsc_pulse_xing uPend (.srcClk(ref_clk), .dstClk(linkClk), .nrst(nrst),
    .srcPulse(pendReq), .dstPulse(pendGo));
  imsc_pulse_xing uTx (.srcClk(linkClk), .dstClk(ref_clk), .nrst(nrst),
    .srcPulse(evTx), .dstPulse(refTx));
  imsc_pulse_xing uRx (.srcClk(linkClk), .dstClk(ref_clk), .nrst(nrst),
    .srcPulse(evRx), .dstPulse(refRx));
  imsc_pulse_xing uStop (.srcClk(linkClk), .dstClk(ref_clk), .nrst(nrst),
    .srcPulse(evStop), .dstPulse(refStop));

  // Static configuration into the link domain
  imsc_sync #(.WIDTH(17), .RST_VAL(17'h00000)) uCfg (.clk(linkClk), .nrst(nrst),
    .d({controllerEnable, roleSelect, clockRateSelect, clockSourceChoice,
        speedSelect, tenBitOwn, ownAddressReg}),
    .q(cfgS));
  // Bus pins, idle high
  imsc_sync #(.WIDTH(2), .RST_VAL(2'h3)) uPins (.clk(linkClk), .nrst(nrst),
    .d({sclIn, sdaIn}), .q(pinS));

  assign {linkEn, linkRole, linkRate, linkSrc, linkSpeed, linkTen, linkOwn} = cfgS;
  assign {sclS, sdaS} = pinS;

  // ****************************************
  // Register side
  // ****************************************
  logic [7:0] linkByte;
  logic refMaster;

  assign refMaster = controllerEnable & roleSelect; // R5

  // Strobe and pending-clear launch requests to the link
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      strobeReq <= 1'b0;
      pendReq <= 1'b0;
    end else begin
      strobeReq <= strobeSet & refMaster & ~pending; // R7 R8
      pendReq <= pendClear & pending & ~roleSelect; // R11 R12
    end
  end

  // Pending bit: busy in master, service request in slave
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pending <= 1'b0;
    end else if (refTx | refRx) begin
      pending <= ~roleSelect; // R11 R12
    end else if (strobeSet & refMaster) begin
      pending <= 1'b1;
    end else if (pendClear & ~roleSelect) begin
      pending <= 1'b0;
    end
  end

  // Byte buffer, firmware write or received byte
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      byteBuffer <= BYTE_RST;
    end else if (refRx | (refTx & ~roleSelect)) begin
      byteBuffer <= linkByte; // R11 R12
    end else if (bufferWrite) begin
      byteBuffer <= bufferWrData;
    end
  end

  // Sticky flags, set wins over clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      transmitDoneFlag <= 1'b0;
      receiveDoneFlag <= 1'b0;
      stopSeenFlag <= 1'b0;
    end else begin
      transmitDoneFlag <= refTx | (transmitDoneFlag & ~flagClear[FLAG_TX]); // R19
      receiveDoneFlag <= refRx | (receiveDoneFlag & ~flagClear[FLAG_RX]); // R19
      stopSeenFlag <= refStop | (stopSeenFlag & ~flagClear[FLAG_STOP]); // R13
    end
  end

  // Interrupt request from enabled flags
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irqReq <= 1'b0;
    end else begin
      irqReq <= |({stopSeenFlag, receiveDoneFlag, transmitDoneFlag} & intEnable); // R19
    end
  end

  // ****************************************
  // Link side: clock divider
  // ****************************************
  logic [15:0] qCnt;
  logic [15:0] qLimit;
  logic [2:0] qShift;
  logic mTick;

  assign qShift = {1'b0, linkRate} + (linkSrc ? SRC_EXTRA_SHIFT : 3'h0);
  assign qLimit = (linkSpeed ? FAST_QTR_CYC : STD_QTR_CYC) << qShift; // R4

  // Quarter-bit tick
  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      qCnt <= 16'h0000;
      mTick <= 1'b0;
    end else begin
      qCnt <= (qCnt == 16'h0000) ? qLimit : qCnt - 16'h0001; // R4
      mTick <= (qCnt == 16'h0000);
    end
  end

  // ****************************************
  // Link side: bus engine
  // ****************************************
  imsc_state_e state;
  logic [1:0] ph;
  logic [3:0] bitCnt;
  logic [7:0] shiftReg;
  logic sclP;
  logic sdaP;
  logic txMode;
  logic rdDir;
  logic stopReq;
  logic ackNext;
  logic addrByte;
  logic tenAddr2;
  logic tenHit;
  logic slvRead;
  logic startDet;
  logic stopDet;
  logic rise;
  logic fall;
  logic step;
  logic tenHi;

  assign startDet = sclS & sclP & sdaP & ~sdaS; // R17
  assign stopDet = sclS & sclP & ~sdaP & sdaS; // R17
  assign rise = sclS & ~sclP;
  assign fall = ~sclS & sclP;
  assign step = mTick & ~(ph == 2'h2 & ~sclS);
  assign tenHi = linkByte[7:3] == TEN_BIT_TAG && linkByte[2:1] == linkOwn[9:8]; // R15

  // Open-drain outputs never drive high
  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end
  end

  // Master and slave sequencing
  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      ph <= 2'h0;
      bitCnt <= 4'h0;
      shiftReg <= BYTE_RST;
      linkByte <= BYTE_RST;
      sclP <= 1'b1;
      sdaP <= 1'b1;
      {txMode, rdDir, stopReq, ackNext, addrByte, tenAddr2, tenHit, slvRead} <= 8'h00;
      {evTx, evRx, evStop, sclOe, sdaOe} <= 5'h00;
    end else begin
      evTx <= 1'b0;
      evRx <= 1'b0;
      evStop <= stopDet & linkEn; // R13
      sclP <= sclS;
      sdaP <= sdaS;
      if (!linkEn) begin
        state <= ST_IDLE;
        sclOe <= 1'b0;
        sdaOe <= 1'b0;
      end else if (!linkRole && startDet) begin
        state <= ST_SBIT; // R3
        bitCnt <= 4'h0;
        addrByte <= 1'b1;
        txMode <= 1'b0;
        sdaOe <= 1'b0;
      end else if (!linkRole && stopDet) begin
        state <= ST_IDLE;
        tenHit <= 1'b0;
        sdaOe <= 1'b0;
        sclOe <= 1'b0;
      end else begin
        case (state)
          ST_IDLE, ST_MHOLD: begin
            if (linkRole && strobeGo) begin
              stopReq <= stopBit; // R9
              bitCnt <= 4'h0;
              ph <= 2'h0;
              if (state == ST_IDLE || repeatStart) begin
                state <= ST_MSTART; // R1 R2 R3
                shiftReg <= targetAddressReg; // R6
                rdDir <= targetAddressReg[0]; // R14
                txMode <= 1'b1;
              end else begin
                state <= ST_MBIT;
                shiftReg <= byteBuffer; // R8 R16
                txMode <= ~rdDir; // R14
              end
            end
          end
          ST_MSTART: begin
            if (step) begin
              ph <= ph + 2'h1;
              case (ph)
                2'h0: sdaOe <= 1'b0;
                2'h1: sclOe <= 1'b0;
                2'h2: sdaOe <= 1'b1; // R17
                default: begin
                  sclOe <= 1'b1;
                  state <= ST_MBIT; // R7
                end
              endcase
            end
          end
          ST_MBIT: begin
            if (step) begin
              ph <= ph + 2'h1;
              case (ph)
                2'h0: sdaOe <= txMode & ~shiftReg[7];
                2'h1: sclOe <= 1'b0;
                2'h2: linkByte <= {linkByte[6:0], sdaS};
                default: begin
                  sclOe <= 1'b1;
                  shiftReg <= {shiftReg[6:0], 1'b0};
                  bitCnt <= bitCnt + 4'h1;
                  if (bitCnt == BITS_PER_BYTE - 4'h1) begin
                    state <= ST_MACK;
                  end
                end
              endcase
            end
          end
          ST_MACK: begin
            if (step) begin
              ph <= ph + 2'h1;
              case (ph)
                2'h0: sdaOe <= ~txMode & ~stopReq;
                2'h1: sclOe <= 1'b0;
                2'h2: sclOe <= 1'b0;
                default: begin
                  sclOe <= 1'b1; // Data line kept, never moves as clock falls
                  evTx <= txMode; // R7 R8
                  evRx <= ~txMode; // R8
                  state <= stopReq ? ST_MSTOP : ST_MHOLD; // R9
                end
              endcase
            end
          end
          ST_MSTOP: begin
            if (step) begin
              ph <= ph + 2'h1;
              case (ph)
                2'h0: sdaOe <= 1'b1;
                2'h1: sclOe <= 1'b0;
                2'h2: sdaOe <= 1'b0; // R9 R17
                default: state <= ST_IDLE;
              endcase
            end
          end
          ST_SBIT: begin
            if (rise) begin
              bitCnt <= bitCnt + 4'h1;
              if (!txMode) begin
                linkByte <= {linkByte[6:0], sdaS};
              end
            end else if (fall && bitCnt == BITS_PER_BYTE) begin
              bitCnt <= 4'h0;
              sdaOe <= 1'b0;
              addrByte <= 1'b0;
              tenAddr2 <= 1'b0;
              if (txMode) begin
                state <= ST_SMACK;
              end else if (addrByte && linkTen && tenHi && !linkByte[0]) begin
                tenAddr2 <= 1'b1; // R15
                slvRead <= 1'b0;
                sdaOe <= 1'b1;
                state <= ST_SACK;
              end else if (addrByte && ((linkTen && tenHi && tenHit) ||
                           (!linkTen && linkByte[7:1] == linkOwn[6:0]))) begin
                slvRead <= linkByte[0]; // R10 R14
                evTx <= linkByte[0]; // R11
                evRx <= ~linkByte[0]; // R11
                ackNext <= 1'b1;
                sclOe <= 1'b1; // R18
                state <= ST_SWAIT;
              end else if (tenAddr2 && linkByte == linkOwn[7:0]) begin
                tenHit <= 1'b1; // R10 R1
                evRx <= 1'b1; // R11
                ackNext <= 1'b1;
                sclOe <= 1'b1; // R18
                state <= ST_SWAIT;
              end else if (!addrByte && !tenAddr2) begin
                evRx <= 1'b1; // R12
                ackNext <= 1'b1;
                sclOe <= 1'b1; // R18
                state <= ST_SWAIT;
              end else begin
                state <= ST_SSKIP; // R10
              end
            end else if (fall && txMode) begin
              sdaOe <= ~shiftReg[6];
              shiftReg <= {shiftReg[6:0], 1'b0};
            end
          end
          ST_SWAIT: begin
            if (pendGo) begin
              sclOe <= 1'b0; // R18
              shiftReg <= byteBuffer;
              if (ackNext) begin
                sdaOe <= 1'b1;
                state <= ST_SACK;
              end else begin
                sdaOe <= ~byteBuffer[7]; // R12
                txMode <= 1'b1;
                bitCnt <= 4'h0;
                state <= ST_SBIT;
              end
            end
          end
          ST_SACK: begin
            if (fall) begin
              ackNext <= 1'b0;
              txMode <= slvRead; // R14
              sdaOe <= slvRead & ~shiftReg[7];
              bitCnt <= 4'h0;
              state <= ST_SBIT;
            end
          end
          ST_SMACK: begin
            if (rise && sdaS) begin
              state <= ST_SSKIP;
            end else if (fall) begin
              evTx <= 1'b1; // R12
              sclOe <= 1'b1; // R18
              state <= ST_SWAIT;
            end
          end
          ST_SSKIP: sdaOe <= 1'b0;
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // imsc_ctrl

// >>> rtl/imsc_pkg.sv
// Constants, states and timing for the two-wire master/slave controller.
// Assumes a 10 MHz register-side clock and a separate link-side clock.
//
// Contract
// R1: 10-bit write, repeated start, then 10-bit read
// R2: New slave needs full addressing sequence again
// R3: 7-bit and 10-bit transfers follow after starts
// R4: Serial clock derived from rate, source, speed select
// R5: Enable plus role select picks master or slave
// R6: Master address byte from target register, LSB direction
// R7: Strobe sends start and address, then transmit-done
// R8: Buffer plus strobe moves byte, raises done flag
// R9: Stop with strobe ends byte with stop
// R10: Slave answers only when own address matches
// R11: Slave buffers address byte, raises flag, firmware clears
// R12: Each slave byte flagged, waits for pending clear
// R13: Slave sets stop-seen flag on stop
// R14: Direction 0 master sends, 1 master receives
// R15: 10-bit first byte is tag plus two bits
// R16: 10-bit low byte goes from byte buffer
// R17: Start and stop are data edges, clock high
// R18: Slave stretches clock low while pending
// R19: Flags raise interrupt when enabled, sticky
package imsc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int LINK_PERIOD_PS = 6000;
  localparam int STD_QTR_NS = 2500;
  localparam int FAST_QTR_NS = 625;
  localparam logic [15:0] STD_QTR_CYC =
    16'((STD_QTR_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
  localparam logic [15:0] FAST_QTR_CYC =
    16'((FAST_QTR_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
  localparam logic [2:0] SRC_EXTRA_SHIFT = 3'h2;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam logic [4:0] TEN_BIT_TAG = 5'h1e;
  localparam int FLAG_TX = 0;
  localparam int FLAG_RX = 1;
  localparam int FLAG_STOP = 2;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] FLAGS_RST = 3'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ****************************************
  // Link-side states
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE, ST_MSTART, ST_MBIT, ST_MACK, ST_MSTOP, ST_MHOLD,
    ST_SBIT, ST_SACK, ST_SMACK, ST_SWAIT, ST_SSKIP
  } imsc_state_e;

endpackage

// >>> rtl/imsc_sync.sv
// Two-flop level synchroniser of parameterised width.
// Assumes the input is a level that holds far longer than two clocks.
`timescale 1ns/100ps
module imsc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // Two stages, first read only by second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // imsc_sync

// >>> rtl/imsc_pulse_xing.sv
// Toggle-based crossing of a one-cycle event between two clocks.
// Assumes events are spaced by at least three destination clocks.
`timescale 1ns/100ps
module imsc_pulse_xing (
  input wire logic srcClk,
  input wire logic dstClk,
  input wire logic nrst,
  input wire logic srcPulse,
  output logic dstPulse
);
  logic srcTog;
  logic meta;
  logic syncd;
  logic last;

  // Source toggles once per event
  always_ff @(posedge srcClk or negedge nrst) begin
    if (!nrst) begin
      srcTog <= 1'b0;
    end else if (srcPulse) begin
      srcTog <= ~srcTog;
    end
  end

  // Destination syncs the toggle and finds its edges
  always_ff @(posedge dstClk or negedge nrst) begin
    if (!nrst) begin
      meta <= 1'b0;
      syncd <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= srcTog;
      syncd <= meta;
      last <= syncd;
    end
  end

  assign dstPulse = syncd ^ last;
endmodule // imsc_pulse_xing

// >>> bench/imsc_ctrl_monitor.sv
// Port checker for the two-wire controller.
// Assumes it is bound to imsc_ctrl and sees only its ports.
`timescale 1ns/100ps
module imsc_ctrl_monitor (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic linkClk,
  input wire logic controllerEnable,
  input wire logic roleSelect,
  input wire logic strobeSet,
  input wire logic [2:0] flagClear,
  input wire logic [2:0] intEnable,
  input wire logic pending,
  input wire logic transmitDoneFlag,
  input wire logic receiveDoneFlag,
  input wire logic stopSeenFlag,
  input wire logic irqReq,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaOut,
  input wire logic sdaOe
);
  // ****
  // Helpers
  // ****
  logic [2:0] flags;
  assign flags = {stopSeenFlag, receiveDoneFlag, transmitDoneFlag};
  sequence takeSeq;
    strobeSet && controllerEnable && roleSelect && !pending;
  endsequence
  sequence doneSeq;
    roleSelect && $fell(pending) && !$past(transmitDoneFlag) && !$past(receiveDoneFlag);
  endsequence
  // Register side
  strobe_take_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    takeSeq |=> pending) else $error("strobe not taken");
  pend_cause_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    roleSelect && $rose(pending) |-> $past(strobeSet)) else $error("busy without strobe");
  done_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    doneSeq |-> transmitDoneFlag || receiveDoneFlag) else $error("done without flag");
  flags_sticky_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    1'b1 |=> (flags & $past(flags) & ~$past(flagClear)) == ($past(flags) & ~$past(flagClear)))
    else $error("flag dropped");
  tx_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    flagClear[0] |=> ($stable(pending) |-> !transmitDoneFlag)) else $error("flag not cleared");
  irq_map_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    1'b1 |=> irqReq == |($past(flags) & $past(intEnable))) else $error("irq wrong");
  // Link side
  quiet_off_a: assert property (@(posedge linkClk) disable iff (!nrst)
    !controllerEnable [*8] |-> !sclOe && !sdaOe) else $error("lines held while off");
  pull_only_a: assert property (@(posedge linkClk) disable iff (!nrst)
    sclOe || sdaOe |-> !sclOut && !sdaOut) else $error("line driven high");
endmodule // imsc_ctrl_monitor

// >>> bench/imsc_far_slave.sv
// Behavioural target on the two-wire bus; acks written bytes.
// Assumes open-drain lines with pull-ups made by the bench.
`timescale 1ns/100ps
module imsc_far_slave #(
  parameter logic [7:0] RD_BYTE = 8'hc3
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic slow,
  output logic sclPull,
  output logic sdaPull,
  output logic [7:0] lastByte,
  output logic [7:0] stops
);
  logic [7:0] sh = 8'h00;
  logic [3:0] cnt = 4'h0;
  logic rd = 1'b0;
  logic ackMe = 1'b0;
  logic first = 1'b0;
  initial begin
    sclPull = 1'b0;
    sdaPull = 1'b0;
    lastByte = 8'h00;
    stops = 8'h00;
  end
  // ****
  // Start and stop detect
  // ****
  always @(negedge sda) begin
    if (scl) begin
      cnt = 4'h0;
      rd = 1'b0;
      first = 1'b1;
    end
  end
  always @(posedge sda) begin
    if (scl) begin
      stops = stops + 8'h01;
      rd = 1'b0;
    end
  end
  // Sample bits on rising clock
  always @(posedge scl) begin
    if (cnt == 4'h8) begin
      cnt = 4'h0;
      if (rd && sda) rd = 1'b0;
    end else begin
      sh = {sh[6:0], sda};
      cnt = cnt + 4'h1;
      if (cnt == 4'h8) begin
        ackMe = !rd;
        if (ackMe) lastByte = sh;
        if (first) rd = sh[0];
        first = 1'b0;
      end
    end
  end
  // Drive ack or read data on falling clock, stretch when slow
  always @(negedge scl) begin
    sdaPull = (cnt == 4'h8) ? ackMe : (rd && !RD_BYTE[~cnt[2:0]]);
    if (slow && cnt == 4'h8) begin
      sclPull = 1'b1;
      #3000 sclPull = 1'b0;
    end
  end
endmodule // imsc_far_slave

// >>> bench/imsc_ctrl_tb.sv
// Self-checking bench for the controller in master and slave roles.
// Assumes the behavioural target model on the bus.
`timescale 1ns/100ps
module imsc_ctrl_tb;
  import imsc_pkg::*;
  localparam logic [7:0] RD = 8'hc3;
  logic ref_clk = 1'b0;
  logic linkClk = 1'b0;
  logic nrst = 1'b0;
  logic controllerEnable = 1'b0;
  logic roleSelect = 1'b1;
  logic [1:0] clockRateSelect = 2'h0;
  logic clockSourceChoice = 1'b0;
  logic speedSelect = 1'b1;
  logic tenBitOwn = 1'b0;
  logic [7:0] targetAddressReg = 8'h00;
  logic [9:0] ownAddressReg = 10'h3ff;
  logic [7:0] bufferWrData = 8'h00;
  logic bufferWrite = 1'b0;
  logic strobeSet = 1'b0;
  logic stopBit = 1'b0;
  logic repeatStart = 1'b0;
  logic pendClear = 1'b0;
  logic [2:0] flagClear = 3'h0;
  logic [2:0] intEnable = 3'h0;
  logic slow = 1'b0;
  logic mC = 1'b0;
  logic mD = 1'b0;
  logic [7:0] byteBuffer, lastByte, stops;
  logic pending, transmitDoneFlag, receiveDoneFlag, stopSeenFlag, irqReq;
  logic sclOut, sclOe, sdaOut, sdaOe, sPullC, sPullD;
  int miscompares = 0;
  int num_checks = 0;
  int cyc;
  wire scl = ~(sclOe | sPullC | mC);
  wire sda = ~(sdaOe | sPullD | mD);
  imsc_ctrl i_dut (.*, .sclIn(scl), .sdaIn(sda));
  imsc_far_slave #(.RD_BYTE(RD)) i_far (.scl(scl), .sda(sda), .slow(slow), .sclPull(sPullC),
    .sdaPull(sPullD), .lastByte(lastByte), .stops(stops));
  // ****
  // Clocks and helpers
  // ****
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    #1.7;
    forever #3 linkClk = ~linkClk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] exp, input logic [7:0] got, input string what);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s exp %h got %h", $time, what, exp, got);
    end
  endtask
  function automatic logic [7:0] fl();
    return {5'h00, stopSeenFlag, receiveDoneFlag, transmitDoneFlag};
  endfunction
  task automatic clr;
    flagClear = 3'h7;
    tick(1);
    flagClear = 3'h0;
    tick(1);
  endtask
  task automatic wbuf(input logic [7:0] d);
    bufferWrData = d;
    bufferWrite = 1'b1;
    tick(1);
    bufferWrite = 1'b0;
    chk(d, byteBuffer, "buffer");
  endtask
  // One strobe, wait for completion, cyc holds busy cycles
  task automatic go(input logic stp, input logic rs);
    stopBit = stp;
    repeatStart = rs;
    strobeSet = 1'b1;
    tick(1);
    strobeSet = 1'b0;
    chk(8'h01, {7'h00, pending}, "busy");
    cyc = 0;
    while (pending !== 1'b0 && cyc < 3000) begin
      tick(1);
      cyc++;
    end
    chk(8'h00, {7'h00, pending}, "done");
    if (stp) tick(100);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_refuse;
    for (int i = 0; i < 2; i++) begin
      controllerEnable = (i == 1);
      roleSelect = (i == 0);
      tick(4);
      strobeSet = 1'b1;
      tick(1);
      strobeSet = 1'b0;
      tick(2);
      chk(8'h00, {6'h00, pending, sdaOe}, "refused strobe");
    end
    controllerEnable = 1'b1;
    roleSelect = 1'b1;
    tick(4);
    $display("t_refuse ended");
  endtask
  task automatic t_ten;
    targetAddressReg = 8'hf2;
    go(1'b0, 1'b0);
    chk(8'hf2, lastByte, "ten high");
    wbuf(8'h3c);
    go(1'b0, 1'b0);
    chk(8'h3c, lastByte, "ten low");
    wbuf(8'h77);
    go(1'b0, 1'b0);
    chk(8'h77, lastByte, "ten data");
    clr;
    targetAddressReg = 8'hf3;
    go(1'b0, 1'b1);
    chk(8'hf3, lastByte, "ten reread");
    chk(8'h01, fl(), "reread flag");
    clr;
    go(1'b1, 1'b0);
    chk(RD, byteBuffer, "ten read");
    clr;
    $display("t_ten ended");
  endtask
  task automatic t_write;
    logic [7:0] s0;
    s0 = stops;
    targetAddressReg = 8'h4c;
    go(1'b0, 1'b0);
    chk(8'h01, fl(), "addr flag");
    chk(8'h4c, lastByte, "addr byte");
    tick(2);
    chk(8'h00, {7'h00, irqReq}, "irq masked");
    intEnable = 3'h1;
    tick(2);
    chk(8'h01, {7'h00, irqReq}, "irq raised");
    clr;
    tick(1);
    chk(8'h00, {7'h00, irqReq}, "irq cleared");
    wbuf(8'h5a);
    go(1'b1, 1'b0);
    chk(8'h05, fl(), "stop flags");
    chk(8'h5a, lastByte, "data byte");
    chk(s0 + 8'h01, stops, "stop on wire");
    clr;
    intEnable = 3'h0;
    $display("t_write ended");
  endtask
  task automatic t_read;
    slow = 1'b1;
    targetAddressReg = 8'h4d;
    go(1'b0, 1'b0);
    chk(8'h01, fl(), "read addr");
    clr;
    go(1'b1, 1'b0);
    chk(8'h06, fl(), "read flags");
    chk(RD, byteBuffer, "read data");
    clr;
    slow = 1'b0;
    $display("t_read ended");
  endtask
  task automatic t_speed;
    int lim;
    for (int i = 0; i < 3; i++) begin
      speedSelect = (i != 0);
      clockSourceChoice = (i == 1);
      clockRateSelect = (i == 2) ? 2'h1 : 2'h0;
      lim = (i == 0) ? int'(STD_QTR_CYC) : int'(FAST_QTR_CYC) * ((i == 1) ? 4 : 2);
      lim = lim * 36 * 6 / 100;
      tick(4);
      go(1'b1, 1'b0);
      chk(8'h01, {7'h00, cyc >= lim}, "rate slow end");
      chk(8'h00, {7'h00, cyc > lim * 3 / 2}, "rate fast end");
      clr;
    end
    speedSelect = 1'b1;
    clockSourceChoice = 1'b0;
    clockRateSelect = 2'h0;
    $display("t_speed ended");
  endtask
  // Bench as master: start (sda falls) or stop (sda rises) with scl high
  task automatic mcond(input logic stp);
    mD = stp;
    tick(2);
    mC = 1'b0;
    tick(2);
    mD = !stp;
    tick(2);
    mC = !stp;
    tick(2);
  endtask
  // Bench as master: eight bits, clock left low after the last
  task automatic mbyte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      mD = !b[i];
      tick(2);
      mC = 1'b0;
      tick(2);
      mC = 1'b1;
    end
    mD = 1'b0;
    tick(4);
  endtask
  // Firmware service, then the ack clock
  task automatic mack(input logic exp);
    pendClear = 1'b1;
    tick(1);
    pendClear = 1'b0;
    tick(3);
    chk({7'h00, exp}, {6'h00, pending, sdaOe}, "slave ack");
    mC = 1'b0;
    tick(2);
    mC = 1'b1;
    tick(2);
  endtask
  task automatic t_slave;
    roleSelect = 1'b0;
    ownAddressReg = 10'h02a;
    tick(4);
    mcond(1'b0);
    mbyte(8'h56);
    chk(8'h00, {6'h00, pending, sclOe}, "foreign address");
    mack(1'b0);
    mcond(1'b1);
    chk(8'h04, fl(), "slave stop");
    clr;
    mcond(1'b0);
    mbyte(8'h54);
    chk(8'h03, {6'h00, pending, sclOe}, "own address");
    chk(8'h54, byteBuffer, "address byte");
    chk(8'h02, fl(), "address flag");
    clr;
    mack(1'b1);
    mbyte(8'ha5);
    chk(8'h03, {6'h00, pending, sclOe}, "data held");
    mack(1'b1);
    mcond(1'b1);
    chk(8'h06, fl(), "data flags");
    chk(8'ha5, byteBuffer, "data byte");
    clr;
    roleSelect = 1'b1;
    $display("t_slave ended");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    tick(10);
    nrst = 1'b1;
    controllerEnable = 1'b1;
    tick(4);
    t_refuse;
    t_ten;
    t_write;
    t_read;
    t_speed;
    t_slave;
    end_sim;
  end
  // Watchdog
  initial begin
    #3000000;
    miscompares++;
    $display("MISMATCH t=%0t watchdog", $time);
    end_sim;
  end
endmodule // imsc_ctrl_tb
bind imsc_ctrl imsc_ctrl_monitor i_mon (.*);
